// *** core/em_dbl_to_int.sv ***
// Converts a double precision start value into an unsigned whole count.
`timescale 1ns/10ps
`default_nettype none
`include "em_cfg.svh"
module em_dbl_to_int (
   input  wire logic [63:0] dbl,
   output logic      [63:0] whole
);
   logic [10:0] expo;
   logic [52:0] mant;
   logic [10:0] shift;
   logic [63:0] mant_w;
   assign expo   = dbl[62:52];
   assign mant   = {1'b1, dbl[51:0]};
   assign shift  = expo - `EM_DBL_BIAS;
   assign mant_w = {11'h000, mant};

   // Negative values and values below one count as zero; values too large saturate.
   always_comb begin
      if (dbl[63] || expo < `EM_DBL_BIAS) begin
         whole = 64'h0000_0000_0000_0000;
      end else if (shift > 11'd63) begin
         whole = 64'hFFFF_FFFF_FFFF_FFFF;
      end else if (shift >= 11'd`EM_DBL_MBITS) begin
         whole = mant_w << (shift - 11'd`EM_DBL_MBITS);
      end else begin
         whole = mant_w >> (11'd`EM_DBL_MBITS - shift);
      end
   end
endmodule : em_dbl_to_int
`default_nettype wire

// *** core/em_meter_core.sv ***
// Metering process image builder and energy counter reset record interpreter.
//
// What this block does
// - Input frame byte 0 carries user data variant code 254.
// - Byte 1 holds overall quality, then current/voltage validity for phases 3, 2, 1.
// - Bytes 8 to 13 hold total active, reactive, apparent power, 16 bits each.
// - Bytes 14-17 total active energy, bytes 18-21 total reactive energy, 32 bits.
// - Byte 22 stays reserved; byte 23 carries the total power factor.
// - Bytes 24 to 31 hold eight signed decimal scaling exponents in fixed order.
// - A valid reset loads selected counters with supplied start values, possibly zero.
// - Writing record number 143 requests the counter reset and preset command.
// - Phase 1 start values are doubles at bytes 8 to 40 in fixed order.
// - Phase 2 start values follow from byte 48, reactive outflow at byte 72.
// - Control byte 1: bit 2 resets, bit 7 defers to rising reset bit.
// - Control byte 2: bit 7 apparent, bit 6 reactive, bit 5 active counters.
//
// The APB register port and the address map were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "em_cfg.svh"
module em_meter_core #(
   parameter int REC_WORDS = 32
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic [11:0]  paddr,
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [31:0]  pwdata,
   input  wire logic [3:0]   pstrb,
   output logic      [31:0]  prdata,
   output logic              pready,
   output logic              pslverr,
   output logic              irq,
   input  wire logic [1:0]   overall_quality_field,
   input  wire logic         phase1_current_valid,
   input  wire logic         phase1_voltage_valid,
   input  wire logic         phase2_current_valid,
   input  wire logic         phase2_voltage_valid,
   input  wire logic         phase3_current_valid,
   input  wire logic         phase3_voltage_valid,
   input  wire logic [15:0]  current_l1,
   input  wire logic [15:0]  current_l2,
   input  wire logic [15:0]  current_l3,
   input  wire logic [15:0]  power_active,
   input  wire logic [15:0]  power_reactive,
   input  wire logic [15:0]  power_apparent,
   input  wire logic [7:0]   power_factor,
   input  wire logic [7:0]   scale_current_l1,
   input  wire logic [7:0]   scale_current_l2,
   input  wire logic [7:0]   scale_current_l3,
   input  wire logic [7:0]   scale_power_active,
   input  wire logic [7:0]   scale_power_reactive,
   input  wire logic [7:0]   scale_power_apparent,
   input  wire logic [7:0]   scale_energy_active,
   input  wire logic [7:0]   scale_energy_reactive,
   input  wire logic [4:0]   energy_tick_l1,
   input  wire logic [4:0]   energy_tick_l2,
   input  wire logic [4:0]   energy_tick_l3,
   input  wire logic         meter_reset_bit,
   output logic      [255:0] frame_data,
   output logic      [2:0]   preset_pending
);
   localparam int CNT_W = 64;
   if (REC_WORDS != 32) begin : g_bad_rec
      $error("em_meter_core: the reset record needs exactly 32 words");
   end

   function automatic logic [15:0] swap16(input logic [15:0] v);
      swap16 = {v[7:0], v[15:8]};
   endfunction : swap16

   function automatic logic [31:0] swap32(input logic [31:0] v);
      swap32 = {v[7:0], v[15:8], v[23:16], v[31:24]};
   endfunction : swap32

   function automatic logic ctl1_ok(input logic [7:0] b);
      ctl1_ok = (b == 8'h00) || (b == 8'h04) || (b == 8'h84);
   endfunction : ctl1_ok

   function automatic logic ctl2_ok(input logic [7:0] b);
      ctl2_ok = (b == 8'h00) || (b == 8'h40) || (b == 8'h60) || (b == 8'h80) ||
                (b == 8'hC0) || (b == 8'hE0);
   endfunction : ctl2_ok

   // Bus decode.
   wire        setup_rd   = psel & ~penable & ~pwrite;
   wire        access     = psel & penable;
   wire        wr_en      = access & pwrite;
   wire        hit_frame  = paddr <= `EM_ADDR_FRAME_HI;
   wire        hit_cmd    = paddr == `EM_ADDR_CMD;
   wire        hit_status = paddr == `EM_ADDR_STATUS;
   wire        hit_mask   = paddr == `EM_ADDR_MASK;
   wire        hit_state  = paddr == `EM_ADDR_STATE;
   wire        hit_rec    = paddr >= `EM_ADDR_REC_LO && paddr <= `EM_ADDR_REC_HI;
   wire        aligned    = paddr[1:0] == 2'b00;
   wire        hit_any    = aligned & (hit_frame | hit_cmd | hit_status | hit_mask |
                                       hit_state | hit_rec);

   logic [31:0]               rec_mem [REC_WORDS];
   logic [255:0]              frame_reg;
   logic [31:0]               prdata_reg;
   logic [`EM_STATUS_W-1:0]   status_reg;
   logic [`EM_STATUS_W-1:0]   mask_reg;
   em_pkg::em_state_e         state_reg;
   em_pkg::em_state_e         state_next;
   logic [3:0]                load_idx_reg;
   logic [2:0]                load_slot_reg;
   logic [1:0]                load_phase_reg;
   logic                      reset_bit_reg;
   logic [5*CNT_W-1:0]        ph_count [3];
   logic [2:0]                ph_applied;
   logic [4:0]                ph_tick [3];
   logic [63:0]               start_dbl;
   logic [63:0]               start_whole;
   logic [255:0]              frame_next;
   logic [31:0]               rd_mux;
   logic [`EM_STATUS_W-1:0]   status_set;
   logic [`EM_STATUS_W-1:0]   status_next;

   assign pready  = access;
   assign pslverr = access & ~hit_any;
   assign prdata  = prdata_reg;
   assign irq     = |(status_reg & mask_reg);

   // Command sequencing.
   wire        cmd_wr     = wr_en & hit_cmd & aligned;
   wire        cmd_good   = pwdata[15:0] == `EM_REC_RESET && pwdata[31:16] == 16'h0000;
   wire        cmd_start  = cmd_wr & cmd_good & (state_reg == em_pkg::EM_IDLE);
   wire [47:0] ctl_bytes  = {rec_mem[1], rec_mem[0][31:16]};
   wire        head_ok    = rec_mem[0][7:0] == `EM_VERSION_1 &&
                            rec_mem[0][15:8] == `EM_RESERVED_VAL;
   logic [2:0] ctl_ok;
   for (genvar p = 0; p < 3; p++) begin : g_ctl_ok
      assign ctl_ok[p] = ctl1_ok(ctl_bytes[16*p +: 8]) & ctl2_ok(ctl_bytes[16*p+8 +: 8]);
   end
   wire        rec_ok     = head_ok & (&ctl_ok);
   wire        in_check   = state_reg == em_pkg::EM_CHECK;
   wire        in_load    = state_reg == em_pkg::EM_LOAD;
   wire        in_arm     = state_reg == em_pkg::EM_ARM;
   wire        load_last  = load_idx_reg == `EM_LAST_START;
   wire        reset_rise = meter_reset_bit & ~reset_bit_reg;

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         em_pkg::EM_IDLE: begin
            if (cmd_start) begin
               state_next = em_pkg::EM_CHECK;
            end
         end
         em_pkg::EM_CHECK: begin
            state_next = rec_ok ? em_pkg::EM_LOAD : em_pkg::EM_IDLE;
         end
         em_pkg::EM_LOAD: begin
            if (load_last) begin
               state_next = em_pkg::EM_ARM;
            end
         end
         em_pkg::EM_ARM: begin
            state_next = em_pkg::EM_IDLE;
         end
      endcase
   end

   // Start value k sits big-endian at record byte 8 + 8k, so phase 2 opens at byte 48.
   wire [4:0] dbl_word = 5'({load_idx_reg, 1'b0} + 5'd2);
   for (genvar j = 0; j < 8; j++) begin : g_dbl_byte
      assign start_dbl[63-8*j -: 8] = rec_mem[dbl_word + 5'(j / 4)][8*(j % 4) +: 8];
   end

   em_dbl_to_int u_dbl (
      .dbl   (start_dbl),
      .whole (start_whole)
   );

   assign ph_tick[0] = energy_tick_l1;
   assign ph_tick[1] = energy_tick_l2;
   assign ph_tick[2] = energy_tick_l3;

   for (genvar p = 0; p < 3; p++) begin : g_phase
      em_phase_ctr #(
         .CNT_W (CNT_W)
      ) u_phase (
         .pclk       (pclk),
         .presetn    (presetn),
         .tick       (ph_tick[p]),
         .stage_we   (in_load && load_phase_reg == 2'(p)),
         .stage_sel  (load_slot_reg),
         .stage_val  (start_whole),
         .arm        (in_arm),
         .ctl1       (ctl_bytes[16*p +: 8]),
         .ctl2       (ctl_bytes[16*p+8 +: 8]),
         .reset_rise (reset_rise),
         .count      (ph_count[p]),
         .pending    (preset_pending[p]),
         .applied    (ph_applied[p])
      );
   end

   // Totals take the inflow counters of all three phases, cut to 32 bits.
   wire [31:0] tot_act = ph_count[0][31:0] + ph_count[1][31:0] + ph_count[2][31:0];
   wire [31:0] tot_rea = ph_count[0][2*CNT_W +: 32] + ph_count[1][2*CNT_W +: 32] +
                         ph_count[2][2*CNT_W +: 32];
   wire [7:0]  quality = {overall_quality_field, phase3_current_valid, phase3_voltage_valid,
                          phase2_current_valid, phase2_voltage_valid, phase1_current_valid,
                          phase1_voltage_valid};

   // Byte n of the frame sits at bits 8n+7..8n; multi-byte fields go out most significant first.
   assign frame_next = {scale_energy_reactive, scale_energy_active, scale_power_apparent,
                        scale_power_reactive, scale_power_active, scale_current_l3,
                        scale_current_l2, scale_current_l1,
                        power_factor, `EM_RESERVED_VAL,
                        swap32(tot_rea), swap32(tot_act),
                        swap16(power_apparent), swap16(power_reactive),
                        swap16(power_active),
                        swap16(current_l3), swap16(current_l2), swap16(current_l1),
                        quality, `EM_VARIANT};
   assign frame_data = frame_reg;

   assign rd_mux = hit_frame  ? frame_reg[32*paddr[4:2] +: 32] :
                   hit_status ? {29'h0000_0000, status_reg} :
                   hit_mask   ? {29'h0000_0000, mask_reg} :
                   hit_state  ? {26'h000_0000, state_reg, 1'b0, preset_pending} :
                   hit_rec    ? rec_mem[paddr[6:2]] : 32'h0000_0000;

   // Events: accepted command, refused command, counters preset.
   assign status_set[`EM_ST_ACCEPT] = in_arm;
   assign status_set[`EM_ST_REJECT] = (cmd_wr & ~cmd_start) | (in_check & ~rec_ok);
   assign status_set[`EM_ST_APPLY]  = |ph_applied;
   // A new event wins over a write-one-to-clear in the same cycle.
   assign status_next = (status_reg & ~((wr_en & hit_status & aligned) ?
                         pwdata[`EM_STATUS_W-1:0] : 3'h0)) | status_set;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frame_reg     <= {248'h0, `EM_VARIANT};
         prdata_reg    <= 32'h0000_0000;
         status_reg    <= `EM_STATUS_RST;
         mask_reg      <= `EM_MASK_RST;
         reset_bit_reg <= 1'b0;
      end else begin
         frame_reg     <= frame_next;
         status_reg    <= status_next;
         reset_bit_reg <= meter_reset_bit;
         if (setup_rd) begin
            prdata_reg <= rd_mux;
         end
         if (wr_en && hit_mask && aligned) begin
            mask_reg <= pwdata[`EM_STATUS_W-1:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg      <= em_pkg::EM_IDLE;
         load_idx_reg   <= 4'h0;
         load_slot_reg  <= 3'h0;
         load_phase_reg <= 2'h0;
      end else begin
         state_reg <= state_next;
         if (!in_load) begin
            load_idx_reg   <= 4'h0;
            load_slot_reg  <= 3'h0;
            load_phase_reg <= 2'h0;
         end else begin
            load_idx_reg   <= load_idx_reg + 4'h1;
            load_slot_reg  <= (load_slot_reg == `EM_LAST_SLOT) ? 3'h0 : load_slot_reg + 3'h1;
            load_phase_reg <= (load_slot_reg == `EM_LAST_SLOT) ? load_phase_reg + 2'h1 :
                              load_phase_reg;
         end
      end
   end

   // Record buffer writes honour byte strobes; writing it while busy corrupts the command.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int w = 0; w < REC_WORDS; w++) begin
            rec_mem[w] <= 32'h0000_0000;
         end
      end else if (wr_en && hit_rec && aligned) begin
         for (int b = 0; b < 4; b++) begin
            if (pstrb[b]) begin
               rec_mem[paddr[6:2]][8*b +: 8] <= pwdata[8*b +: 8];
            end
         end
      end
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   AST_VARIANT: assert property (frame_reg[7:0] == 8'hFE)
      else $error("frame byte 0 lost the variant code");
   // The frame is registered, so the first edge after reset still shows the reset image.
   AST_QUALITY: assert property ($past(presetn) |-> frame_reg[15:8] == $past(quality))
      else $error("quality byte does not follow the validity inputs");
   AST_POWER: assert property ($past(presetn) |->
                               frame_reg[71:64] == $past(power_active[15:8]) &&
                               frame_reg[79:72] == $past(power_active[7:0]))
      else $error("total active power misplaced in the frame");
   AST_ENERGY: assert property ($past(presetn) |->
                                frame_reg[119:112] == $past(tot_act[31:24]) &&
                                frame_reg[175:168] == $past(tot_rea[7:0]))
      else $error("total energies misplaced in the frame");
   AST_RESERVED: assert property ($past(presetn) |->
                                  frame_reg[183:176] == 8'h00 &&
                                  frame_reg[191:184] == $past(power_factor))
      else $error("reserved byte or power factor wrong");
   AST_SCALE: assert property ($past(presetn) |->
                               frame_reg[199:192] == $past(scale_current_l1) &&
                               frame_reg[255:248] == $past(scale_energy_reactive))
      else $error("scaling exponents misplaced");
   AST_CMD: assert property (state_reg == em_pkg::EM_IDLE && cmd_wr && !cmd_good
                             |=> state_reg == em_pkg::EM_IDLE && status_reg[1])
      else $error("a wrong record number started a command");
   AST_REJECT: assert property (in_check && !rec_ok
                                |=> state_reg == em_pkg::EM_IDLE && !in_arm ##1 !(|ph_applied))
      else $error("an illegal record went on to preset counters");
   AST_LOAD: assert property (in_check && rec_ok
                              |=> in_load [*8] ##1 in_load [*7] ##1 in_arm)
      else $error("start value load did not take fifteen cycles");
endmodule : em_meter_core
`default_nettype wire

// *** core/em_phase_ctr.sv ***
// Five energy counters of one phase with staged start values and deferred preset.
`timescale 1ns/10ps
`default_nettype none
`include "em_cfg.svh"
module em_phase_ctr #(
   parameter int CNT_W = 64
) (
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic [4:0]            tick,
   input  wire logic                  stage_we,
   input  wire logic [2:0]            stage_sel,
   input  wire logic [CNT_W-1:0]      stage_val,
   input  wire logic                  arm,
   input  wire logic [7:0]            ctl1,
   input  wire logic [7:0]            ctl2,
   input  wire logic                  reset_rise,
   output logic      [5*CNT_W-1:0]    count,
   output logic                       pending,
   output logic                       applied
);
   if (CNT_W < 32 || CNT_W > 64) begin : g_bad_width
      $error("em_phase_ctr: CNT_W must lie between 32 and 64");
   end

   logic [CNT_W-1:0] stage_mem [`EM_N_SLOT];
   logic [4:0]       sel_new;
   logic [4:0]       mask_reg;
   logic             pend_reg;
   logic             arm_rst;
   logic             arm_now;
   logic             arm_defer;
   logic [4:0]       apply_mask;

   // Slots 0..4 are active in, active out, reactive in, reactive out, apparent.
   assign sel_new    = {ctl2[`EM_C2_APP_BIT], {2{ctl2[`EM_C2_REA_BIT]}},
                        {2{ctl2[`EM_C2_ACT_BIT]}}};
   assign arm_rst    = arm & ctl1[`EM_C1_RESET_BIT];
   assign arm_now    = arm_rst & ~ctl1[`EM_C1_DEFER_BIT];
   assign arm_defer  = arm_rst & ctl1[`EM_C1_DEFER_BIT];
   assign applied    = arm_now | (pend_reg & reset_rise & ~arm_rst);
   assign apply_mask = arm_now ? sel_new : mask_reg;
   assign pending    = pend_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_reg <= 1'b0;
         mask_reg <= 5'h00;
      end else begin
         if (arm_defer) begin
            pend_reg <= 1'b1;
            mask_reg <= sel_new;
         end else if (applied) begin
            pend_reg <= 1'b0;
         end
      end
   end

   for (genvar i = 0; i < `EM_N_SLOT; i++) begin : g_slot
      logic [CNT_W-1:0] cnt_reg;
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            cnt_reg      <= '0;
            stage_mem[i] <= '0;
         end else begin
            if (stage_we && stage_sel == 3'(i)) begin
               stage_mem[i] <= stage_val;
            end
            // A preset takes the staged value, which may well be zero.
            if (applied && apply_mask[i]) begin
               cnt_reg <= stage_mem[i];
            end else if (tick[i]) begin
               cnt_reg <= cnt_reg + 1'b1;
            end
         end
      end
      assign count[i*CNT_W +: CNT_W] = cnt_reg;

      AST_PRESET: assert property (@(posedge pclk) disable iff (!presetn)
         applied && apply_mask[i] && !(stage_we && stage_sel == 3'(i))
         |=> cnt_reg == $past(stage_mem[i]))
         else $error("counter did not take its start value");
   end

   AST_DEFER: assert property (@(posedge pclk) disable iff (!presetn)
      arm_defer |-> !applied ##1 pend_reg)
      else $error("deferred preset applied early or not held");
   AST_EDGE: assert property (@(posedge pclk) disable iff (!presetn)
      pend_reg && !reset_rise && !arm |-> !applied)
      else $error("deferred preset applied without a rising reset bit");
   AST_SELECT: assert property (@(posedge pclk) disable iff (!presetn)
      arm_now |-> apply_mask == sel_new && apply_mask[0] == ctl2[`EM_C2_ACT_BIT])
      else $error("counter selection does not follow the second control byte");
endmodule : em_phase_ctr
`default_nettype wire

// *** shared/em_cfg.svh ***
// Register offsets, record layout, field positions and reset values of the meter image block.
`ifndef EM_CFG_SVH
`define EM_CFG_SVH
`define EM_ADDR_FRAME_LO 12'h000
`define EM_ADDR_FRAME_HI 12'h01C
`define EM_ADDR_CMD      12'h020
`define EM_ADDR_STATUS   12'h024
`define EM_ADDR_MASK     12'h028
`define EM_ADDR_STATE    12'h02C
`define EM_ADDR_REC_LO   12'h080
`define EM_ADDR_REC_HI   12'h0FC
`define EM_REC_RESET     16'h008F
`define EM_VARIANT       8'hFE
`define EM_VERSION_1     8'h00
`define EM_RESERVED_VAL  8'h00
`define EM_C1_RESET_BIT  2
`define EM_C1_DEFER_BIT  7
`define EM_C2_ACT_BIT    5
`define EM_C2_REA_BIT    6
`define EM_C2_APP_BIT    7
`define EM_ST_ACCEPT     0
`define EM_ST_REJECT     1
`define EM_ST_APPLY      2
`define EM_STATUS_W      3
`define EM_STATUS_RST    3'h0
`define EM_MASK_RST      3'h0
`define EM_N_SLOT        5
`define EM_N_START       15
`define EM_LAST_SLOT     3'h4
`define EM_LAST_START    4'hE
`define EM_DBL_BIAS      11'h3FF
`define EM_DBL_MBITS     52
`endif

// *** shared/em_pkg.sv ***
// Types shared by the meter image block.
package em_pkg;
   typedef enum logic [1:0] {
      EM_IDLE  = 2'b00,
      EM_CHECK = 2'b01,
      EM_LOAD  = 2'b11,
      EM_ARM   = 2'b10
   } em_state_e;
endpackage : em_pkg

// *** tb/em_head_model.sv ***
// Head station model that issues register bus transfers for the controller.
`timescale 1ns/10ps
`default_nettype none
module em_head_model (
   input  wire logic        pclk,
   output logic      [11:0] paddr,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic      [31:0] pwdata,
   output logic      [3:0]  pstrb,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   int hang = 0;
   initial begin
      {paddr, psel, penable, pwrite, pwdata} = '0;
      pstrb = 4'hF;
   end
   // Record words go first and the command word last, so a record is never half written.
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) hang++;
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~d;
   endtask : xfer
endmodule : em_head_model
`default_nettype wire

// *** tb/em_meter_core_tb.sv ***
// Self-checking bench for the meter image and counter reset record block.
`timescale 1ns/10ps
`default_nettype none
module em_meter_core_tb;
   logic         pclk = 1'b0;
   logic         presetn = 1'b0;
   logic [11:0]  paddr;
   logic [31:0]  pwdata, prdata;
   logic [3:0]   pstrb;
   logic         psel, penable, pwrite, pready, pslverr, irq;
   logic         mrb = 1'b0;
   logic [1:0]   qq = 2'b10;
   logic [5:0]   vb = 6'b10_1101;
   logic [15:0]  cur [3] = '{16'h1234, 16'h5678, 16'h9ABC};
   logic [15:0]  pw [3] = '{16'hA1B2, 16'hC3D4, 16'hE5F6};
   logic [7:0]   pf = 8'h5A;
   logic [7:0]   sc [8] = '{8'hF0, 8'h01, 8'hF2, 8'h03, 8'hF4, 8'h05, 8'hF6, 8'h07};
   logic [4:0]   tk = 5'h00;
   logic [255:0] fr;
   logic [2:0]   pend;
   int           fail_count = 0;
   int           checks = 0;
   always #12.5 pclk = ~pclk;
   em_head_model i_head (.pclk, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata,
      .pready, .pslverr);
   em_meter_core i_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb,
      .prdata, .pready, .pslverr, .irq, .overall_quality_field(qq),
      .phase1_current_valid(vb[1]), .phase1_voltage_valid(vb[0]), .phase2_current_valid(vb[3]),
      .phase2_voltage_valid(vb[2]), .phase3_current_valid(vb[5]), .phase3_voltage_valid(vb[4]),
      .current_l1(cur[0]), .current_l2(cur[1]), .current_l3(cur[2]), .power_active(pw[0]),
      .power_reactive(pw[1]), .power_apparent(pw[2]), .power_factor(pf),
      .scale_current_l1(sc[0]), .scale_current_l2(sc[1]), .scale_current_l3(sc[2]),
      .scale_power_active(sc[3]), .scale_power_reactive(sc[4]), .scale_power_apparent(sc[5]),
      .scale_energy_active(sc[6]), .scale_energy_reactive(sc[7]), .energy_tick_l1(tk),
      .energy_tick_l2(5'h00), .energy_tick_l3(5'h00), .meter_reset_bit(mrb), .frame_data(fr),
      .preset_pending(pend));
   function automatic logic [7:0] fb(input int n);
      return fr[8*n+:8];
   endfunction : fb
   function automatic logic [63:0] en(input int n);
      return 64'({fb(n), fb(n + 1), fb(n + 2), fb(n + 3)});
   endfunction : en
   task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic test_done;
      fail_count += i_head.hang;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : test_done
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      i_head.xfer(1'b1, a, d, q, e);
      if (i_head.hang != 0) test_done();
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic xe);
      logic [31:0] q;
      logic        e;
      i_head.xfer(1'b0, a, 32'h0000_0000, q, e);
      if (i_head.hang != 0) test_done();
      chk("read data", 64'(exp), 64'(q));
      chk("slave error", 64'(xe), 64'(e));
   endtask : rd
   // Polling keeps the record buffer untouched until the command has fully finished.
   task automatic wait_idle;
      logic [31:0] q;
      logic        e;
      for (int n = 0; n < 40; n++) begin
         i_head.xfer(1'b0, 12'h02C, 32'h0000_0000, q, e);
         if (i_head.hang != 0) test_done();
         if (q[5:4] === 2'b00) return;
      end
      chk("idle wait", 64'h0, 64'h1);
      test_done();
   endtask : wait_idle
   task automatic rec(input logic [31:0] w0, w1, w2, w6, w12);
      for (int i = 0; i < 32; i++) begin
         wr(12'h080 + 12'(4 * i), i == 0 ? w0 : i == 1 ? w1 : i == 2 ? w2 :
            i == 6 ? w6 : i == 12 ? w12 : 32'h0000_0000);
      end
      wr(12'h020, 32'h0000_008F);
      wait_idle();
   endtask : rec
   task automatic t_frame;
      rd(12'h000, {cur[0][7:0], cur[0][15:8], qq, vb, 8'hFE}, 1'b0);
      chk("quality", 64'({qq, vb}), 64'(fb(1)));
      for (int i = 0; i < 3; i++) begin
         chk("power", 64'(pw[i]), 64'({fb(8 + 2 * i), fb(9 + 2 * i)}));
      end
      chk("factor", 64'(pf), 64'(fb(23)));
      for (int i = 0; i < 8; i++) begin
         chk("scaling", 64'(sc[i]), 64'(fb(24 + i)));
      end
   endtask : t_frame
   task automatic t_imm;
      rec(32'hE004_0000, 32'h0, 32'h0000_5940, 32'h0000_2440, 32'h0);
      rd(12'h024, 32'h0000_0005, 1'b0);
      chk("active total", 64'd100, en(14));
      chk("reactive total", 64'd10, en(18));
      wr(12'h028, 32'h0000_0001);
      @(negedge pclk);
      chk("irq", 64'h1, 64'(irq));
      wr(12'h024, 32'h0000_0007);
      @(negedge pclk);
      chk("irq", 64'h0, 64'(irq));
   endtask : t_imm
   task automatic t_rej;
      rec(32'hE004_0001, 32'h0, 32'h0000_6940, 32'h0, 32'h0);
      rec(32'hE002_0000, 32'h0, 32'h0000_6940, 32'h0, 32'h0);
      wr(12'h020, 32'h0000_008E);
      wait_idle();
      rd(12'h024, 32'h0000_0002, 1'b0);
      chk("kept total", 64'd100, en(14));
      wr(12'h024, 32'h0000_0007);
   endtask : t_rej
   task automatic t_defer;
      rec(32'h0, 32'h0000_E084, 32'h0, 32'h0, 32'h0000_0040);
      chk("pending", 64'h2, 64'(pend));
      chk("held total", 64'd100, en(14));
      @(posedge pclk);
      tk <= 5'h01;
      @(posedge pclk);
      tk <= 5'h00;
      mrb <= 1'b1;
      repeat (4) @(posedge pclk);
      chk("pending", 64'h0, 64'(pend));
      chk("loaded total", 64'd103, en(14));
      mrb <= 1'b0;
   endtask : t_defer
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_frame();
      t_imm();
      t_rej();
      t_defer();
      rd(12'h030, 32'h0000_0000, 1'b1);
      test_done();
   end
endmodule : em_meter_core_tb
`default_nettype wire
